/* File: rtl/t2cs_pkg.sv */
// Purpose: Constants for the timer 2 control and status block
// Assumes: 8-bit special-function bus, one system clock
// Notes: Field positions refer to the timer2_control byte
//
// Summary of operation
// RQ1: High byte wrap sets high overflow flag.
// RQ2: 16-bit wrap FFFF to 0000 sets flag.
// RQ3: High flag with enable raises interrupt.
// RQ4: Flags cleared only by software writing zero.
// RQ5: Low byte wrap sets low flag always.
// RQ6: Low flag interrupts when low enable set.
// RQ7: Bit 4 turns capture mode on.
// RQ8: Split bit selects two 8-bit counters.
// RQ9: Counting only while run control is one; in split mode the low byte counts with run control zero.
// RQ10: Split mode run gates high byte only.
// RQ11: Bit 1 reads zero, ignores writes.
// RQ12: Clock select: system clock/12 or external/8.
// RQ13: Per-byte select overrides with system clock.
// RQ14: Control at 0xC8 page 0, bit access.
// RQ15: 16-bit wrap loads 16-bit reload value.
// RQ16: Split wrap reloads each byte separately.
// RQ17: Capture edge copies count, sets high flag.
// RQ18: Per-byte select one gives system clock.
// RQ19: Hardware set beats same-cycle software clear.
package t2cs_pkg;
    // ********************************
    // Addresses
    // ********************************
    localparam logic [7:0] CTL_ADDR = 8'hC8;
    localparam logic [7:0] RLL_ADDR = 8'hCA;
    localparam logic [7:0] RLH_ADDR = 8'hCB;
    localparam logic [7:0] CNTL_ADDR = 8'hCC;
    localparam logic [7:0] CNTH_ADDR = 8'hCD;
    localparam logic [7:0] TMR_PAGE = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // ********************************
    // Control fields
    // ********************************
    localparam int HI_FLAG_BIT = 7;
    localparam int LO_FLAG_BIT = 6;
    localparam int LO_IRQ_EN_BIT = 5;
    localparam int CAP_EN_BIT = 4;
    localparam int SPLIT_BIT = 3;
    localparam int RUN_BIT = 2;
    localparam int UNUSED_BIT = 1;
    localparam int XCLK_BIT = 0;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [15:0] WORD_MAX = 16'hFFFF;
    // ********************************
    // Timing
    // ********************************
    localparam int SYS_DIV = 12;
    localparam int EXT_DIV = 8;
endpackage

/* File: rtl/t2cs_prescale.sv */
// Purpose: System clock /12 tick and external /8 edges
// Assumes: ext_sync already passed the synchroniser
// Notes: External divider counts synchronised rising edges
`timescale 1ns/100ps
module t2cs_prescale #(
    parameter int SYS_DIV = t2cs_pkg::SYS_DIV,
    parameter int EXT_DIV = t2cs_pkg::EXT_DIV
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ext_sync,
    output logic div12_tick,
    output logic ext_rise,
    output logic ext_fall
);
    localparam int SW = $clog2(SYS_DIV);
    localparam int EW = $clog2(EXT_DIV);
    localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);

    logic [SW-1:0] sys_cnt_ff;
    logic [SW-1:0] nxt_sys_cnt;
    logic [EW-1:0] ext_cnt_ff;
    logic [EW-1:0] nxt_ext_cnt;
    logic ext_prev_ff;
    logic div_prev_ff;
    logic pin_rise;

    // Edge detect on the second sync flop only
    assign pin_rise = ext_sync & ~ext_prev_ff;
    assign div12_tick = (sys_cnt_ff == SYS_LAST);
    assign ext_rise = ext_cnt_ff[EW-1] & ~div_prev_ff;
    assign ext_fall = ~ext_cnt_ff[EW-1] & div_prev_ff;

    always_comb begin
        nxt_sys_cnt = div12_tick ? '0 : sys_cnt_ff + 1'b1;
        nxt_ext_cnt = pin_rise ? ext_cnt_ff + 1'b1 : ext_cnt_ff;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sys_cnt_ff <= '0;
            ext_cnt_ff <= '0;
            ext_prev_ff <= 1'b0;
            div_prev_ff <= 1'b0;
        end else begin
            sys_cnt_ff <= nxt_sys_cnt;
            ext_cnt_ff <= nxt_ext_cnt;
            ext_prev_ff <= ext_sync;
            div_prev_ff <= ext_cnt_ff[EW-1];
        end
    end
endmodule

/* File: rtl/t2cs_sync.sv */
// Purpose: Two-flop synchroniser for a pin level
// Assumes: Input is asynchronous to ref_clk
// Notes: First flop feeds only the second
`timescale 1ns/100ps
module t2cs_sync (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_ff;
    logic sync_ff;
    logic nxt_meta;
    logic nxt_sync;

    always_comb begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff;
endmodule

/* File: rtl/t2cs_timer2.sv */
// Purpose: Timer 2 control register, counter, reload and capture
// Assumes: Special-function bus on ref_clk, one write per cycle
// Notes: Software write to a counter byte beats a same-cycle count
`timescale 1ns/100ps
module t2cs_timer2 (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_page,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_bit_wr,
    input wire logic [2:0] sfr_bit_sel,
    input wire logic sfr_bit_val,
    output logic [7:0] sfr_rdata,
    input wire logic timer_irq_enable,
    input wire logic high_byte_clock_select,
    input wire logic low_byte_clock_select,
    input wire logic ext_osc_pin,
    output logic timer_irq,
    output logic high_ovf_pulse,
    output logic low_ovf_pulse,
    output logic high_run_en,
    output logic low_run_en,
    output logic split_mode_select,
    output logic capture_mode_enable,
    output logic external_clock_select
);
    // ********************************
    // Clock sources
    // ********************************
    logic ext_sync;
    logic div12_tick;
    logic ext_rise;
    logic ext_fall;

    t2cs_sync u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .async_in(ext_osc_pin),
        .sync_out(ext_sync)
    );

    t2cs_prescale u_pre (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .ext_sync(ext_sync),
        .div12_tick(div12_tick),
        .ext_rise(ext_rise),
        .ext_fall(ext_fall)
    );

    // ********************************
    // State
    // ********************************
    logic [7:0] ctl_ff;
    logic [7:0] nxt_ctl;
    logic [7:0] cnt_lo_ff;
    logic [7:0] nxt_cnt_lo;
    logic [7:0] cnt_hi_ff;
    logic [7:0] nxt_cnt_hi;
    logic [7:0] rl_lo_ff;
    logic [7:0] nxt_rl_lo;
    logic [7:0] rl_hi_ff;
    logic [7:0] nxt_rl_hi;
    logic hi_ovf_ff;
    logic lo_ovf_ff;

    logic page_ok;
    logic ctl_sel;
    logic ctl_byte_wr;
    logic ctl_bit_wr;
    logic lo_tick;
    logic hi_tick;
    logic lo_wrap;
    logic hi_wrap;
    logic cap_event;
    logic set_hi;
    logic set_lo;
    logic [7:0] wr_ctl;
    logic [15:0] cnt_word;

    assign split_mode_select = ctl_ff[t2cs_pkg::SPLIT_BIT];        // [RQ8]
    assign capture_mode_enable = ctl_ff[t2cs_pkg::CAP_EN_BIT];     // [RQ7]
    assign external_clock_select = ctl_ff[t2cs_pkg::XCLK_BIT];
    assign cnt_word = {cnt_hi_ff, cnt_lo_ff};

    // ********************************
    // Bus decode
    // ********************************
    assign page_ok = (sfr_page == t2cs_pkg::TMR_PAGE);
    assign ctl_sel = page_ok && (sfr_addr == t2cs_pkg::CTL_ADDR);  // [RQ14]
    assign ctl_byte_wr = ctl_sel && sfr_wr;
    assign ctl_bit_wr = ctl_sel && sfr_bit_wr;                     // [RQ14]

    always_comb begin
        wr_ctl = ctl_ff;
        if (ctl_byte_wr) begin
            wr_ctl = sfr_wdata;
        end else if (ctl_bit_wr) begin
            wr_ctl[sfr_bit_sel] = sfr_bit_val;
        end
        wr_ctl[t2cs_pkg::UNUSED_BIT] = 1'b0;                       // [RQ11]
    end

    always_comb begin
        if (!page_ok) begin
            sfr_rdata = t2cs_pkg::UNMAPPED_READ;
        end else if (sfr_addr == t2cs_pkg::CTL_ADDR) begin
            sfr_rdata = ctl_ff;
        end else if (sfr_addr == t2cs_pkg::RLL_ADDR) begin
            sfr_rdata = rl_lo_ff;
        end else if (sfr_addr == t2cs_pkg::RLH_ADDR) begin
            sfr_rdata = rl_hi_ff;
        end else if (sfr_addr == t2cs_pkg::CNTL_ADDR) begin
            sfr_rdata = cnt_lo_ff;
        end else if (sfr_addr == t2cs_pkg::CNTH_ADDR) begin
            sfr_rdata = cnt_hi_ff;
        end else begin
            sfr_rdata = t2cs_pkg::UNMAPPED_READ;
        end
    end

    // ********************************
    // Count enables
    // ********************************
    // Capture mode never counts on the external clock it measures
    function automatic logic pick_tick(input logic fast_sel);
        if (fast_sel) begin
            pick_tick = 1'b1;                                      // [RQ18]
        end else if (ctl_ff[t2cs_pkg::XCLK_BIT] &&
                     !ctl_ff[t2cs_pkg::CAP_EN_BIT]) begin
            pick_tick = ext_rise;                                  // [RQ12]
        end else begin
            pick_tick = div12_tick;                                // [RQ12]
        end
    endfunction

    always_comb begin
        if (ctl_ff[t2cs_pkg::SPLIT_BIT]) begin
            low_run_en = 1'b1;                                     // [RQ10]
            lo_tick = pick_tick(low_byte_clock_select);            // [RQ13]
            hi_tick = ctl_ff[t2cs_pkg::RUN_BIT] &&
                      pick_tick(high_byte_clock_select);           // [RQ13]
        end else begin
            low_run_en = ctl_ff[t2cs_pkg::RUN_BIT];                // [RQ9]
            lo_tick = low_run_en && pick_tick(low_byte_clock_select);
            hi_tick = lo_tick && (cnt_lo_ff == t2cs_pkg::BYTE_MAX);
        end
    end
    assign high_run_en = ctl_ff[t2cs_pkg::RUN_BIT];                // [RQ9]

    assign lo_wrap = lo_tick && (cnt_lo_ff == t2cs_pkg::BYTE_MAX); // [RQ5]
    assign hi_wrap = hi_tick && (cnt_hi_ff == t2cs_pkg::BYTE_MAX); // [RQ1] [RQ2]
    assign cap_event = ctl_ff[t2cs_pkg::CAP_EN_BIT] && ext_fall;   // [RQ17]
    assign set_hi = hi_wrap || cap_event;
    assign set_lo = lo_wrap;
    assign hi_ovf_ff = ctl_ff[t2cs_pkg::HI_FLAG_BIT];
    assign lo_ovf_ff = ctl_ff[t2cs_pkg::LO_FLAG_BIT];

    // ********************************
    // Next state
    // ********************************
    always_comb begin
        nxt_ctl = wr_ctl;
        // Set wins so an overflow in a clearing write is kept
        if (set_hi) begin
            nxt_ctl[t2cs_pkg::HI_FLAG_BIT] = 1'b1;                 // [RQ19] [RQ4]
        end
        if (set_lo) begin
            nxt_ctl[t2cs_pkg::LO_FLAG_BIT] = 1'b1;                 // [RQ19] [RQ4]
        end

        nxt_cnt_lo = cnt_lo_ff;
        nxt_cnt_hi = cnt_hi_ff;
        if (!ctl_ff[t2cs_pkg::SPLIT_BIT] && hi_wrap) begin
            nxt_cnt_lo = rl_lo_ff;                                 // [RQ15]
            nxt_cnt_hi = rl_hi_ff;                                 // [RQ15]
        end else begin
            if (lo_wrap && ctl_ff[t2cs_pkg::SPLIT_BIT]) begin
                nxt_cnt_lo = rl_lo_ff;                             // [RQ16]
            end else if (lo_tick) begin
                nxt_cnt_lo = cnt_lo_ff + 8'h01;
            end
            if (hi_wrap) begin
                nxt_cnt_hi = rl_hi_ff;                             // [RQ16]
            end else if (hi_tick) begin
                nxt_cnt_hi = cnt_hi_ff + 8'h01;
            end
        end

        nxt_rl_lo = rl_lo_ff;
        nxt_rl_hi = rl_hi_ff;
        if (cap_event) begin
            nxt_rl_lo = cnt_lo_ff;                                 // [RQ17]
            nxt_rl_hi = cnt_hi_ff;                                 // [RQ17]
        end

        if (page_ok && sfr_wr) begin
            if (sfr_addr == t2cs_pkg::RLL_ADDR) begin
                nxt_rl_lo = sfr_wdata;
            end else if (sfr_addr == t2cs_pkg::RLH_ADDR) begin
                nxt_rl_hi = sfr_wdata;
            end else if (sfr_addr == t2cs_pkg::CNTL_ADDR) begin
                nxt_cnt_lo = sfr_wdata;
            end else if (sfr_addr == t2cs_pkg::CNTH_ADDR) begin
                nxt_cnt_hi = sfr_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctl_ff <= t2cs_pkg::CTL_RESET;                         // [RQ14]
            cnt_lo_ff <= t2cs_pkg::BYTE_RESET;
            cnt_hi_ff <= t2cs_pkg::BYTE_RESET;
            rl_lo_ff <= t2cs_pkg::BYTE_RESET;
            rl_hi_ff <= t2cs_pkg::BYTE_RESET;
        end else begin
            ctl_ff <= nxt_ctl;
            cnt_lo_ff <= nxt_cnt_lo;
            cnt_hi_ff <= nxt_cnt_hi;
            rl_lo_ff <= nxt_rl_lo;
            rl_hi_ff <= nxt_rl_hi;
        end
    end

    // ********************************
    // Interrupt and strobes
    // ********************************
    assign timer_irq = timer_irq_enable &&
        (hi_ovf_ff ||                                              // [RQ3]
         (ctl_ff[t2cs_pkg::LO_IRQ_EN_BIT] && lo_ovf_ff));          // [RQ6]
    assign high_ovf_pulse = set_hi;
    assign low_ovf_pulse = set_lo;

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_capture_edge;
        capture_mode_enable && ext_fall && !(page_ok && sfr_wr);
    endsequence

    sequence s_word_wrap;
        !split_mode_select && lo_tick && cnt_word == t2cs_pkg::WORD_MAX
        && !(page_ok && (sfr_wr || sfr_bit_wr));
    endsequence

    a_high_wrap_flag: assert property ( // [RQ1]
        hi_wrap |=> hi_ovf_ff)
        else $error("high wrap did not set flag");

    a_word_wrap_reload: assert property ( // [RQ2]
        s_word_wrap |=> hi_ovf_ff && cnt_word == $past({rl_hi_ff, rl_lo_ff}))
        else $error("16-bit wrap missed flag or reload");

    a_irq_high: assert property ( // [RQ3]
        timer_irq_enable && hi_ovf_ff |-> timer_irq)
        else $error("high flag did not raise irq");

    a_flag_sticky: assert property ( // [RQ4]
        hi_ovf_ff && !ctl_sel |=> hi_ovf_ff)
        else $error("high flag cleared without a write");

    a_low_wrap_flag: assert property ( // [RQ5]
        lo_wrap |=> lo_ovf_ff)
        else $error("low wrap did not set flag");

    a_irq_low_gate: assert property ( // [RQ6]
        timer_irq |-> timer_irq_enable && (hi_ovf_ff ||
        (ctl_ff[t2cs_pkg::LO_IRQ_EN_BIT] && lo_ovf_ff)))
        else $error("irq without qualified flag");

    a_bit1_zero: assert property ( // [RQ11]
        ctl_sel |-> sfr_rdata[t2cs_pkg::UNUSED_BIT] == 1'b0)
        else $error("unused bit read back non-zero");

    a_stopped_holds: assert property ( // [RQ9]
        !split_mode_select && !high_run_en && !(page_ok && sfr_wr)
        |=> $stable(cnt_word))
        else $error("counter moved while stopped");

    a_split_low_runs: assert property ( // [RQ10]
        split_mode_select && low_byte_clock_select && !high_run_en
        && !(page_ok && sfr_wr) |=> cnt_lo_ff != $past(cnt_lo_ff))
        else $error("low byte stalled in split mode");

    a_capture_copy: assert property ( // [RQ17]
        s_capture_edge |=> {rl_hi_ff, rl_lo_ff} == $past(cnt_word)
        && hi_ovf_ff)
        else $error("capture did not copy count");

    a_set_beats_clear: assert property ( // [RQ19]
        set_lo && ctl_byte_wr && !sfr_wdata[t2cs_pkg::LO_FLAG_BIT]
        |=> lo_ovf_ff)
        else $error("clear beat a same-cycle set");

    a_ext_tick_count: assert property ( // [RQ12]
        !split_mode_select && !capture_mode_enable && external_clock_select
        && high_run_en && !low_byte_clock_select && !ext_rise
        && !(page_ok && sfr_wr) |=> $stable(cnt_word))
        else $error("counted without an external tick");
endmodule

/* File: tb/timer2_control_status_tb.sv */
// Purpose: Self-checking bench for the timer 2 control and status block
// Assumes: Bench drives every port itself, 250 MHz ref_clk
// Notes: Inputs change 1 ns after each rising edge
`timescale 1ns/100ps
module timer2_control_status_tb;
    // ********************************
    // Signals and clock
    // ********************************
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_page = 8'h00;
    logic sfr_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_bit_wr = 1'b0;
    logic [2:0] sfr_bit_sel = 3'h0;
    logic sfr_bit_val = 1'b0;
    logic [7:0] sfr_rdata;
    logic timer_irq_enable = 1'b1;
    logic high_byte_clock_select = 1'b0;
    logic low_byte_clock_select = 1'b1;
    logic ext_osc_pin = 1'b0;
    logic timer_irq, high_ovf_pulse, low_ovf_pulse, high_run_en, low_run_en;
    logic split_mode_select, capture_mode_enable, external_clock_select;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    localparam logic [7:0] CTL = t2cs_pkg::CTL_ADDR;
    localparam logic [7:0] RLL = t2cs_pkg::RLL_ADDR;
    localparam logic [7:0] RLH = t2cs_pkg::RLH_ADDR;
    localparam logic [7:0] CNL = t2cs_pkg::CNTL_ADDR;
    localparam logic [7:0] CNH = t2cs_pkg::CNTH_ADDR;

    always #2 ref_clk = ~ref_clk;

    t2cs_timer2 uut (
        .ref_clk(ref_clk), .nrst(nrst), .sfr_addr(sfr_addr),
        .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel),
        .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata),
        .timer_irq_enable(timer_irq_enable),
        .high_byte_clock_select(high_byte_clock_select),
        .low_byte_clock_select(low_byte_clock_select),
        .ext_osc_pin(ext_osc_pin), .timer_irq(timer_irq),
        .high_ovf_pulse(high_ovf_pulse), .low_ovf_pulse(low_ovf_pulse),
        .high_run_en(high_run_en), .low_run_en(low_run_en),
        .split_mode_select(split_mode_select),
        .capture_mode_enable(capture_mode_enable),
        .external_clock_select(external_clock_select)
    );
    // ********************************
    // Shared tasks
    // ********************************
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Limit well above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 8000) begin
            err_count++;
            final_report();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [7:0] pg);
        @(posedge ref_clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_page = pg;
        sfr_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        sfr_wr = 1'b0;
        sfr_page = 8'h00;
    endtask

    task automatic bw(input logic [2:0] sel, input logic val);
        @(posedge ref_clk);
        #1;
        sfr_addr = CTL;
        sfr_bit_sel = sel;
        sfr_bit_val = val;
        sfr_bit_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        sfr_bit_wr = 1'b0;
    endtask

    // Read is combinational, so one settle step is enough
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        #1;
        sfr_addr = a;
        #1;
        chk8(sfr_rdata, exp);
    endtask

    // Stops on the event cycle, one edge before the flags land
    task automatic wait_ovf(input logic hi);
        int n;
        for (n = 0; n < 600; n++) begin
            @(posedge ref_clk);
            #1;
            if ((hi ? high_ovf_pulse : low_ovf_pulse) === 1'b1) begin
                break;
            end
        end
        chk1(n < 600, 1'b1);
    endtask

    task automatic pin_rises(input int n);
        repeat (n) begin
            repeat (5) @(posedge ref_clk);
            #1 ext_osc_pin = 1'b1;
            repeat (5) @(posedge ref_clk);
            #1 ext_osc_pin = 1'b0;
        end
    endtask
    // ********************************
    // Scenarios
    // ********************************
    task automatic t_reset_access();
        rd(CTL, t2cs_pkg::CTL_RESET);
        rd(RLH, 8'h00);
        chk1(timer_irq, 1'b0);
        chk1(low_run_en, 1'b0);
        wr(CTL, 8'h02, 8'h00);
        rd(CTL, 8'h00);
        bw(3'h1, 1'b1);
        rd(CTL, 8'h00);
        wr(CNL, 8'h5A, 8'h01);
        rd(CNL, 8'h00);
        rd(8'hC9, t2cs_pkg::UNMAPPED_READ);
    endtask

    task automatic t_wrap16();
        wr(RLL, 8'h34, 8'h00);
        wr(RLH, 8'h12, 8'h00);
        wr(CNL, 8'hFE, 8'h00);
        wr(CNH, 8'hFF, 8'h00);
        wr(CTL, 8'h04, 8'h00);
        chk1(high_run_en, 1'b1);
        wait_ovf(1'b1);
        chk1(low_ovf_pulse, 1'b1);
        rd(CNL, 8'h34);
        rd(CNH, 8'h12);
        rd(CTL, 8'hC4);
        chk1(timer_irq, 1'b1);
    endtask

    task automatic t_flags_irq();
        bw(3'h2, 1'b0);
        wr(CNL, 8'h77, 8'h00);
        repeat (20) @(posedge ref_clk);
        rd(CNL, 8'h77);
        rd(CTL, 8'hC0);
        bw(3'h7, 1'b0);
        rd(CTL, 8'h40);
        chk1(timer_irq, 1'b0);
        bw(3'h5, 1'b1);
        rd(CTL, 8'h60);
        chk1(timer_irq, 1'b1);
        @(posedge ref_clk);
        #1 timer_irq_enable = 1'b0;
        #1 chk1(timer_irq, 1'b0);
        @(posedge ref_clk);
        #1 timer_irq_enable = 1'b1;
        bw(3'h6, 1'b0);
        rd(CTL, 8'h20);
        chk1(timer_irq, 1'b0);
    endtask

    task automatic t_split();
        wr(RLL, 8'h55, 8'h00);
        wr(RLH, 8'hAA, 8'h00);
        wr(CNH, 8'hF0, 8'h00);
        wr(CNL, 8'hFE, 8'h00);
        wr(CTL, 8'h08, 8'h00);
        chk1(split_mode_select, 1'b1);
        chk1(low_run_en, 1'b1);
        chk1(high_run_en, 1'b0);
        wait_ovf(1'b0);
        chk1(high_ovf_pulse, 1'b0);
        rd(CNL, 8'h55);
        rd(CNH, 8'hF0);
        rd(CTL, 8'h48);
        @(posedge ref_clk);
        #1 high_byte_clock_select = 1'b1;
        wr(CNH, 8'hFE, 8'h00);
        bw(3'h2, 1'b1);
        wait_ovf(1'b1);
        rd(CNH, 8'hAA);
        rd(CTL, 8'hCC);
        // Clearing write lands on a low wrap, so the flag must stay
        wr(CNL, 8'hFE, 8'h00);
        wr(CTL, 8'h08, 8'h00);
        rd(CTL, 8'h48);
        @(posedge ref_clk);
        #1 high_byte_clock_select = 1'b0;
    endtask

    task automatic t_div12();
        @(posedge ref_clk);
        #1 low_byte_clock_select = 1'b0;
        wr(CTL, 8'h04, 8'h00);
        chk1(external_clock_select, 1'b0);
        wr(CNH, 8'h00, 8'h00);
        wr(CNL, 8'h00, 8'h00);
        repeat (23) @(posedge ref_clk);
        rd(CNL, 8'h02);
    endtask

    // Pin idle until now, so the /8 divider starts from zero
    task automatic t_ext8();
        wr(CTL, 8'h05, 8'h00);
        chk1(external_clock_select, 1'b1);
        wr(CNH, 8'h00, 8'h00);
        wr(CNL, 8'h00, 8'h00);
        pin_rises(16);
        repeat (10) @(posedge ref_clk);
        rd(CNL, 8'h02);
    endtask

    task automatic t_capture();
        int n;
        @(posedge ref_clk);
        #1 low_byte_clock_select = 1'b1;
        wr(CTL, 8'h00, 8'h00);
        wr(RLL, 8'h00, 8'h00);
        wr(RLH, 8'h00, 8'h00);
        wr(CNH, 8'h01, 8'h00);
        wr(CNL, 8'h00, 8'h00);
        wr(CTL, 8'h14, 8'h00);
        chk1(capture_mode_enable, 1'b1);
        pin_rises(8);
        sfr_addr = CTL;
        for (n = 0; n < 100; n++) begin
            @(posedge ref_clk);
            #2;
            if (sfr_rdata[7] === 1'b1) begin
                break;
            end
        end
        chk1(n < 100, 1'b1);
        rd(CTL, 8'h94);
        rd(RLH, 8'h01);
    endtask
    // ********************************
    // Main sequence
    // ********************************
    initial begin
        repeat (20) @(posedge ref_clk);
        #1 nrst = 1'b1;
        t_reset_access();
        t_wrap16();
        t_flags_irq();
        t_split();
        t_div12();
        t_ext8();
        t_capture();
        final_report();
    end
endmodule
